/* File: core/epil_pkg.sv */
// constants and types for the external pin interrupt block
package epil_pkg;
	// ========================================
	// register indices (byte address = index * 4)
	localparam logic [7:0] IDX_EXT_CFG = 8'hF9;
	localparam logic [7:0] IDX_KEY_CFG = 8'hFB;
	localparam logic [7:0] IDX_FILT = 8'hFA;
	localparam logic [7:0] IDX_SENSE = 8'hF0;
	localparam logic [7:0] IDX_STAT = 8'hF1;
	localparam logic [7:0] IDX_MASK = 8'hF2;
	localparam logic [7:0] IDX_ROUTE = 8'hF3;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] BYTE_OFS = 2'h0;
	// ========================================
	// sources and pins
	localparam int N_EXT = 3;
	localparam int N_KEY = 4;
	localparam int N_SRC = 4;
	localparam int SRC_KEY = 3;
	localparam logic PIN_IDLE = 1'b1;
	// ========================================
	// filter clock select codes
	localparam logic [1:0] FILT_OFF = 2'h0;
	localparam logic [1:0] FILT_F1 = 2'h1;
	localparam logic [1:0] FILT_MID = 2'h2;
	localparam logic [1:0] FILT_SLOW = 2'h3;
	localparam int DIV_MID = 8;
	localparam int DIV_SLOW = 32;
	// ========================================
	// route bits
	localparam int ROUTE_A_POS = 0;
	localparam int ROUTE_B_POS = 1;
	// ========================================
	// types
	typedef struct packed {
		logic ok;
		logic wr;
		logic [7:0] idx;
	} epil_aphase_t;

	// enable bit of channel k; both-edge bit sits one above, filter field at it
	function automatic int ext_en_pos(input int k);
		ext_en_pos = (k == 0) ? 0 : (k == 1) ? 2 : 6;
	endfunction : ext_en_pos
endpackage : epil_pkg

/* File: core/epil_top.sv */
// external pin and key input interrupt logic with AHB-Lite registers
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// What this block does
// - pin requests only while its enable set
// - edge chosen by both-edge and sense bits
// - both-edge bit: 0 one edge, 1 both
// - enable bits gate input, reset to zero
// - rewriting both-edge bit may raise flag
// - two-bit field picks filter sampling clock
// - flag set after three matching samples
// - second input routed from one of two pins
// - enabled key edge raises shared request if no other key active
// - key request wakes from wait and stop
// - key enable bit: 0 off, 1 on
// - key polarity: 0 falling, 1 rising; reset zero
// - falling key held low blocks other keys
// - rising key held high blocks other keys
// - acknowledge clears the request flag
module epil_top #(
	parameter int DIV_MID_P = epil_pkg::DIV_MID,
	parameter int DIV_SLOW_P = epil_pkg::DIV_SLOW
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// pins
	input wire logic ext_irq_pin0,
	input wire logic ext_irq_pin1_a,
	input wire logic ext_irq_pin1_b,
	input wire logic ext_irq_pin3,
	input wire logic [3:0] key_input_pin,
	// interrupt side
	input wire logic [epil_pkg::N_SRC-1:0] irq_ack,
	output logic [epil_pkg::N_SRC-1:0] request_pending_flag,
	output logic irq,
	output logic wake_req
);
	import epil_pkg::*;

	// ========================================
	// registers
	logic [7:0] ext_irq_pin_config;
	logic [7:0] key_irq_pin_config;
	logic [7:0] ext_pin_filter_config;
	logic [N_EXT-1:0] edge_sense_select;
	logic [1:0] route_cfg;
	logic [N_SRC-1:0] stat;
	logic [N_SRC-1:0] mask;
	epil_aphase_t aph;
	logic rd_pend;
	logic [31:0] rd_mux;
	logic wr_go;
	logic [N_SRC-1:0] w1c;
	logic [N_SRC-1:0] stat_set;
	logic [N_EXT-1:0] pl_chg;
	logic [N_EXT-1:0] ext_en_v;
	logic [N_EXT-1:0] ext_pl_v;
	logic [7:0] sync1;
	logic [7:0] sync2;
	logic [N_EXT-1:0] ext_lvl;
	logic [4:0] div_cnt;
	logic [N_EXT-1:0] samp_en;
	logic [2:0] samp [N_EXT];
	logic [N_EXT-1:0] filt_lvl;
	logic [N_EXT-1:0] prev_lvl;
	logic [N_EXT-1:0] ext_evt;
	logic [N_KEY-1:0] key_lvl;
	logic [N_KEY-1:0] key_active;
	logic key_comb;
	logic key_prev;
	logic key_evt;
	logic [N_KEY-1:0] key_low_hold;
	logic [N_KEY-1:0] key_high_hold;

	// ========================================
	// bus slave
	assign hresp = 1'b0;
	assign hreadyout = ~rd_pend; // reads take one wait state
	assign wr_go = aph.ok & aph.wr;

	// capture address phase; only aligned words inside the map
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph <= '0;
		end else if (hready) begin
			aph.ok <= hsel & htrans[1] & (haddr[1:0] == BYTE_OFS)
				& (haddr[11:10] == BYTE_OFS);
			aph.wr <= hwrite;
			aph.idx <= haddr[9:2];
		end else begin
			aph.ok <= aph.ok & ~aph.wr;
		end
	end

	// read data loaded one cycle after the address, so a write just
	// before is always seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend <= 1'b0;
			hrdata <= '0;
		end else if (rd_pend) begin
			rd_pend <= 1'b0;
			hrdata <= rd_mux;
		end else begin
			rd_pend <= hready & hsel & htrans[1] & ~hwrite;
		end
	end

	// read mux; unmapped words read zero
	always_comb begin
		rd_mux = '0;
		case (aph.idx)
			IDX_EXT_CFG: rd_mux[7:0] = ext_irq_pin_config;
			IDX_KEY_CFG: rd_mux[7:0] = key_irq_pin_config;
			IDX_FILT: rd_mux[7:0] = ext_pin_filter_config;
			IDX_SENSE: rd_mux[N_EXT-1:0] = edge_sense_select;
			IDX_ROUTE: rd_mux[1:0] = route_cfg;
			IDX_STAT: rd_mux[N_SRC-1:0] = stat;
			IDX_MASK: rd_mux[N_SRC-1:0] = mask;
			default: rd_mux = '0;
		endcase
	end

	// ========================================
	// configuration writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_irq_pin_config <= RST_BYTE;
			key_irq_pin_config <= RST_BYTE;
			ext_pin_filter_config <= RST_BYTE;
			edge_sense_select <= '0;
			route_cfg <= '0;
			mask <= '0;
		end else if (wr_go) begin
			case (aph.idx)
				IDX_EXT_CFG: ext_irq_pin_config <= hwdata[7:0];
				IDX_KEY_CFG: key_irq_pin_config <= hwdata[7:0];
				IDX_FILT: ext_pin_filter_config <= hwdata[7:0];
				IDX_SENSE: edge_sense_select <= hwdata[N_EXT-1:0];
				IDX_ROUTE: route_cfg <= hwdata[1:0];
				IDX_MASK: mask <= hwdata[N_SRC-1:0];
				default: ;
			endcase
		end
	end

	// per-channel fields; a both-edge bit that changes in a write that sets the channel's
	// enable bit is reported as a request, as the pin logic would glitch
	always_comb begin
		for (int k = 0; k < N_EXT; k++) begin
			ext_en_v[k] = ext_irq_pin_config[ext_en_pos(k)];
			ext_pl_v[k] = ext_irq_pin_config[ext_en_pos(k) + 1];
			pl_chg[k] = wr_go && (aph.idx == IDX_EXT_CFG)
				&& hwdata[ext_en_pos(k)]
				&& (hwdata[ext_en_pos(k) + 1] != ext_pl_v[k]);
		end
	end

	// ========================================
	// pin synchronisers: ext0, ext1a, ext1b, ext3, keys
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '1;
			sync2 <= '1;
		end else begin
			sync1 <= {key_input_pin, ext_irq_pin3, ext_irq_pin1_b,
				ext_irq_pin1_a, ext_irq_pin0};
			sync2 <= sync1;
		end
	end

	// second input uses pin b only when route a set and route b clear
	assign ext_lvl[0] = sync2[0];
	assign ext_lvl[1] = (route_cfg[ROUTE_A_POS] & ~route_cfg[ROUTE_B_POS])
		? sync2[2] : sync2[1];
	assign ext_lvl[2] = sync2[3];
	assign key_lvl = sync2[7:4];

	// ========================================
	// sampling clock divider
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= '0;
		end else if (div_cnt == 5'(DIV_SLOW_P - 1)) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 5'h01;
		end
	end

	// sample strobe per channel from its clock select field
	always_comb begin
		for (int k = 0; k < N_EXT; k++) begin
			case (ext_pin_filter_config[ext_en_pos(k) +: 2])
				FILT_F1: samp_en[k] = 1'b1;
				FILT_MID: samp_en[k] = (div_cnt % 5'(DIV_MID_P)) == 5'h00;
				FILT_SLOW: samp_en[k] = div_cnt == 5'h00;
				default: samp_en[k] = 1'b0;
			endcase
		end
	end

	// three-sample filter; bypassed when the select field is off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int k = 0; k < N_EXT; k++) begin
				samp[k] <= {3{PIN_IDLE}};
			end
			filt_lvl <= {N_EXT{PIN_IDLE}};
			prev_lvl <= {N_EXT{PIN_IDLE}};
		end else begin
			prev_lvl <= filt_lvl;
			for (int k = 0; k < N_EXT; k++) begin
				if (ext_pin_filter_config[ext_en_pos(k) +: 2] == FILT_OFF) begin
					filt_lvl[k] <= ext_lvl[k];
				end else if (samp_en[k]) begin
					samp[k] <= {samp[k][1:0], ext_lvl[k]};
					if (samp[k][1:0] == {2{ext_lvl[k]}}) begin
						filt_lvl[k] <= ext_lvl[k];
					end
				end
			end
		end
	end

	// edge choice: both edges, or the one the sense bit names
	always_comb begin
		for (int k = 0; k < N_EXT; k++) begin
			if (ext_pl_v[k]) begin
				ext_evt[k] = filt_lvl[k] != prev_lvl[k];
			end else if (edge_sense_select[k]) begin
				ext_evt[k] = filt_lvl[k] & ~prev_lvl[k];
			end else begin
				ext_evt[k] = ~filt_lvl[k] & prev_lvl[k];
			end
			ext_evt[k] = ext_evt[k] & ext_en_v[k];
		end
	end

	// ========================================
	// key inputs: one shared detector, so a pin sitting at its active
	// level masks edges on the others
	always_comb begin
		for (int k = 0; k < N_KEY; k++) begin
			key_active[k] = key_irq_pin_config[2 * k]
				& (key_irq_pin_config[2 * k + 1]
				? key_lvl[k] : ~key_lvl[k]);
		end
	end
	assign key_comb = |key_active;
	assign key_evt = key_comb & ~key_prev;

	// previous combined level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_prev <= 1'b0;
		end else begin
			key_prev <= key_comb;
		end
	end

	// ========================================
	// sticky request flags: set beats clear from write or acknowledge
	assign stat_set = {key_evt, ext_evt | pl_chg};
	assign w1c = (wr_go && aph.idx == IDX_STAT) ? hwdata[N_SRC-1:0] : '0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat <= '0;
		end else begin
			stat <= (stat & ~(w1c | irq_ack)) | stat_set;
		end
	end

	assign request_pending_flag = stat;
	assign irq = |(stat & mask);
	// wake works with the clock gated off elsewhere; held until cleared
	assign wake_req = stat[SRC_KEY];

	// keys parked at their active level, rebuilt from the raw fields so
	// the blocking checks do not lean on the detector's own terms
	always_comb begin
		for (int k = 0; k < N_KEY; k++) begin
			key_low_hold[k] = key_irq_pin_config[2 * k]
				& ~key_irq_pin_config[2 * k + 1] & ~key_lvl[k];
			key_high_hold[k] = key_irq_pin_config[2 * k]
				& key_irq_pin_config[2 * k + 1] & key_lvl[k];
		end
	end

	// ========================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_ext_enable_gate: assert property (
		(!ext_en_v[0] && !pl_chg[0] && !stat[0]) |=> !stat[0])
		else $error("pin event on disabled channel");
	a_edge_sense_pick: assert property (
		(ext_evt[0] && !ext_pl_v[0]) |-> filt_lvl[0] == edge_sense_select[0])
		else $error("single edge did not follow sense bit");
	a_both_edge_flag: assert property (
		(ext_en_v[2] && ext_pl_v[2] && filt_lvl[2] != prev_lvl[2])
		|=> request_pending_flag[2])
		else $error("both-edge change did not set flag");
	a_filter_hold: assert property (
		!samp_en[0] |=> $stable(samp[0]))
		else $error("filter sampled without its strobe");
	a_filter_three: assert property (
		($changed(filt_lvl[0]) && $past(ext_pin_filter_config[1:0]) != FILT_OFF)
		|-> samp[0] == {3{filt_lvl[0]}})
		else $error("filter moved without three samples");
	a_reconfig_flag: assert property (
		pl_chg[2] |=> stat[2])
		else $error("both-edge rewrite did not raise flag");
	a_key_wake: assert property (
		key_evt |=> stat[SRC_KEY] && wake_req)
		else $error("key edge did not raise request and wake");
	a_key_blocked: assert property (
		($past(|key_low_hold) && |key_low_hold) |-> !key_evt)
		else $error("key edge seen while a falling key held low");
	a_key_high_block: assert property (
		($past(|key_high_hold) && |key_high_hold) |-> !key_evt)
		else $error("key edge seen while a rising key held high");
	a_ack_clear: assert property (
		(irq_ack[SRC_KEY] && !stat_set[SRC_KEY])
		|=> !request_pending_flag[SRC_KEY] && !wake_req)
		else $error("acknowledge did not clear flag");
	a_pin_sync_delay: assert property (
		$past(hresetn, 2) |-> ext_lvl[0] == $past(ext_irq_pin0, 2))
		else $error("pin reached logic without two flops");
endmodule : epil_top

/* File: tb/epil_src.sv */
// model of the keys and signal sources wired to the pins
`timescale 1ns/1ps
module epil_src (
	// levels toward the block
	output logic [3:0] ext_lvl,
	output logic [3:0] key_lvl
);
	// ========================================
	// idle high: a released button floats up
	initial begin
		ext_lvl = 4'hF;
		key_lvl = 4'hF;
	end
	// called just after a clock edge, so levels move off the edge
	task drive(input logic [3:0] e, input logic [3:0] k);
		ext_lvl <= e;
		key_lvl <= k;
	endtask : drive
endmodule : epil_src

/* File: tb/epil_top_bench.sv */
// self-checking bench for the pin interrupt block
`timescale 1ns/1ps
module epil_top_bench;
	import epil_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, wake;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic [3:0] ack, flg, e, k;
	int error_cnt, cmp_count, cyc;
	epil_src src (.ext_lvl(e), .key_lvl(k));
	// short dividers keep the slow filter codes quick
	epil_top #(.DIV_MID_P(2), .DIV_SLOW_P(4)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .ext_irq_pin0(e[0]),
		.ext_irq_pin1_a(e[1]), .ext_irq_pin1_b(e[2]),
		.ext_irq_pin3(e[3]), .key_input_pin(k), .irq_ack(ack),
		.request_pending_flag(flg), .irq(irq), .wake_req(wake));
	// ========================================
	// clock, reset and hang guard
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	task close_out;
		$display("mismatches %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk
	// ========================================
	// one single transfer; each phase waits for hready at an edge
	task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {2'h0, idx, 2'h0};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus
	task rdc(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask : rdc
	// config write, then drop any flag the rewrite itself raised
	task cfg(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
		bus(1'b1, IDX_STAT, 8'h0F);
	endtask : cfg
	// pins move, then time for sync, filter and status to settle
	task pins(input logic [3:0] pe, input logic [3:0] pk, input int n);
		src.drive(pe, pk);
		repeat (n) @(posedge hclk);
	endtask : pins
	// ========================================
	// scenarios
	task t_ext;
		rdc(IDX_EXT_CFG, 32'h0);
		rdc(IDX_KEY_CFG, 32'h0);
		rdc(8'h10, 32'h0);
		chk(hresp, 1'b0);
		pins(4'hE, 4'hF, 8);
		chk(flg, 4'h0);
		pins(4'hF, 4'hF, 8);
		cfg(IDX_EXT_CFG, 8'h01);
		rdc(IDX_EXT_CFG, 32'h1);
		pins(4'hE, 4'hF, 8);
		chk(flg, 4'h1);
		bus(1'b1, IDX_MASK, 8'h01);
		// mask lands on the edge the task returns at; irq follows it
		@(posedge hclk);
		chk(irq, 1'b1);
		bus(1'b1, IDX_STAT, 8'h0F);
		pins(4'hF, 4'hF, 8);
		chk(flg, 4'h0);
		// rising sense: the fall is ignored, the rise is taken
		bus(1'b1, IDX_SENSE, 8'h01);
		pins(4'hE, 4'hF, 8);
		chk(flg, 4'h0);
		pins(4'hF, 4'hF, 8);
		chk(flg, 4'h1);
		chk(irq, 1'b1);
		rdc(IDX_STAT, 32'h1);
		cfg(IDX_SENSE, 8'h00);
	endtask : t_ext
	task t_both;
		// sense bit ignored whenever both edges are chosen
		bus(1'b1, IDX_EXT_CFG, 8'hC0);
		// the flag is set on the edge the write lands; look one later
		@(posedge hclk);
		chk(flg, 4'h4);
		bus(1'b1, IDX_STAT, 8'h0F);
		pins(4'h7, 4'hF, 8);
		chk(flg, 4'h4);
		bus(1'b1, IDX_STAT, 8'h0F);
		pins(4'hF, 4'hF, 8);
		chk(flg, 4'h4);
		cfg(IDX_EXT_CFG, 8'h01);
	endtask : t_both
	task t_filt;
		cfg(IDX_FILT, 8'h01);
		pins(4'hE, 4'hF, 2);
		pins(4'hF, 4'hF, 10);
		chk(flg, 4'h0);
		for (int c = 1; c < 4; c++) begin
			cfg(IDX_FILT, 8'(c));
			pins(4'hE, 4'hF, 40);
			chk(flg, 4'h1);
			pins(4'hF, 4'hF, 40);
			bus(1'b1, IDX_STAT, 8'h0F);
		end
		cfg(IDX_FILT, 8'h00);
	endtask : t_filt
	task t_route;
		bus(1'b1, IDX_ROUTE, 8'h01);
		cfg(IDX_EXT_CFG, 8'h04);
		pins(4'hB, 4'hF, 8);
		chk(flg, 4'h2);
		cfg(IDX_STAT, 8'h0F);
		pins(4'hD, 4'hF, 8);
		chk(flg, 4'h0);
		pins(4'hF, 4'hF, 8);
	endtask : t_route
	task t_key;
		cfg(IDX_KEY_CFG, 8'h05);
		rdc(IDX_KEY_CFG, 32'h5);
		pins(4'hF, 4'hB, 8);
		chk(flg, 4'h0);
		pins(4'hF, 4'hA, 8);
		chk({flg, wake}, 5'h11);
		ack <= 4'h8;
		@(posedge hclk);
		ack <= 4'h0;
		@(posedge hclk);
		chk(flg, 4'h0);
		pins(4'hF, 4'h8, 8);
		chk(flg, 4'h0);
		pins(4'hF, 4'hF, 8);
		cfg(IDX_KEY_CFG, 8'h07);
		pins(4'hF, 4'hD, 8);
		chk(flg, 4'h0);
	endtask : t_key
	// ========================================
	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwdata = 32'h0;
		ack = 4'h0;
		error_cnt = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_ext();
		t_both();
		t_filt();
		t_route();
		t_key();
		close_out();
	end
endmodule : epil_top_bench
